// ===== rtl/or_return_rotate_exec.sv
`timescale 1ns/1ps
// Summary of operation
// - idle op changes nothing, just advances
// - accumulator gets accumulator OR memory byte
// - accumulator gets accumulator OR immediate
// - memory byte gets accumulator OR memory
// - subroutine exit pops PC, flags untouched
// - subroutine exit with load also loads accumulator immediate
// - interrupt exit pops PC, sets interrupt enable
// - pending interrupt served before resuming main
// - memory byte rotates left, bit7 into bit0
// - jumps take two cycles with dummy
module or_return_rotate_exec
  import exec_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // decoded instruction
  input wire logic instr_valid_i,
  input wire op_e op_i,
  input wire logic [DATA_W-1:0] imm_i,
  input wire logic [DATA_W-1:0] mem_addr_i,
  input wire logic [PC_W-1:0] jump_addr_i,
  // data memory
  input wire logic [DATA_W-1:0] mem_rdata_i,
  output logic mem_we_o,
  output logic [DATA_W-1:0] mem_waddr_o,
  output logic [DATA_W-1:0] mem_wdata_o,
  // return stack
  input wire logic [PC_W-1:0] stack_top_i,
  output logic stack_pop_o,
  output logic stack_push_o,
  output logic [PC_W-1:0] stack_push_data_o,
  // interrupt controller
  input wire logic irq_pending_i,
  input wire logic gie_clear_i,
  output logic global_interrupt_enable_o,
  output logic irq_ack_o,
  // core state
  output logic [PC_W-1:0] pc_o,
  output logic [DATA_W-1:0] acc_o,
  output logic zero_o,
  output logic busy_o
);
  state_e state_ff;
  logic [PC_W-1:0] pc_ff;
  logic [DATA_W-1:0] acc_ff;
  logic zero_ff;
  logic gie_ff;
  logic mem_we_ff;
  logic [DATA_W-1:0] mem_waddr_ff;
  logic [DATA_W-1:0] mem_wdata_ff;
  logic pop_ff;
  logic push_ff;
  logic [PC_W-1:0] push_data_ff;
  logic irq_ack_ff;
  logic take;
  logic is_return;
  logic irq_take;
  alu_if a ();

  bit_alu u_alu (.a(a));

  // only immediate OR feeds the instruction byte to the ALU, all others feed memory
  assign a.acc = acc_ff;
  assign a.operand = (op_i == OR_IMM_TO_ACC_OP) ? imm_i : mem_rdata_i;
  assign take = ce_i && instr_valid_i && (state_ff == ST_EXEC);
  assign is_return = (op_i == SUBROUTINE_EXIT_OP) || (op_i == SUBROUTINE_EXIT_LOAD_OP)
    || (op_i == INTERRUPT_EXIT_OP);
  assign irq_take = take && (op_i == INTERRUPT_EXIT_OP) && irq_pending_i;

  // control transfers hold off the next instruction for one dummy cycle
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_ff <= ST_EXEC;
    else if (ce_i)
    begin
      case (state_ff)
        ST_EXEC:
          if (take && (is_return || op_i == UNCONDITIONAL_JUMP_OP))
            state_ff <= ST_DUMMY;
        ST_DUMMY:
          state_ff <= ST_EXEC;
        default:
          state_ff <= ST_EXEC;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pc_ff <= PC_RST;
    else if (take)
    begin
      case (op_i)
        UNCONDITIONAL_JUMP_OP:
          pc_ff <= jump_addr_i;
        SUBROUTINE_EXIT_OP, SUBROUTINE_EXIT_LOAD_OP:
          pc_ff <= stack_top_i;
        INTERRUPT_EXIT_OP:
          pc_ff <= irq_pending_i ? IRQ_VECTOR : stack_top_i;
        default:
          pc_ff <= pc_ff + PC_W'(1);
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      acc_ff <= ACC_RST;
    else if (take)
    begin
      case (op_i)
        OR_MEM_TO_ACC_OP, OR_IMM_TO_ACC_OP:
          acc_ff <= a.or_res;
        SUBROUTINE_EXIT_LOAD_OP:
          acc_ff <= imm_i;
        default:
          acc_ff <= acc_ff;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      zero_ff <= ZERO_RST;
    else if (take && (op_i == OR_MEM_TO_ACC_OP || op_i == OR_IMM_TO_ACC_OP
      || op_i == OR_INTO_MEMORY_OP))
      zero_ff <= a.or_zero;
  end

  // a set in the same cycle as a clear wins
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      gie_ff <= GIE_RST;
    else if (ce_i)
    begin
      if (take && op_i == INTERRUPT_EXIT_OP)
        gie_ff <= 1'b1;
      else if (gie_clear_i)
        gie_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mem_we_ff <= 1'b0;
      mem_waddr_ff <= '0;
      mem_wdata_ff <= '0;
    end
    else if (ce_i)
    begin
      mem_we_ff <= take && (op_i == OR_INTO_MEMORY_OP || op_i == ROTATE_LEFT_OP);
      if (take && op_i == OR_INTO_MEMORY_OP)
      begin
        mem_waddr_ff <= mem_addr_i;
        mem_wdata_ff <= a.or_res;
      end
      else if (take && op_i == ROTATE_LEFT_OP)
      begin
        mem_waddr_ff <= mem_addr_i;
        mem_wdata_ff <= a.rot_res;
      end
    end
  end

  // a pending interrupt pushes the restored address back: the stack depth is
  // unchanged and the handler's own exit resumes the main program
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pop_ff <= 1'b0;
      push_ff <= 1'b0;
      push_data_ff <= PC_RST;
      irq_ack_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      pop_ff <= take && is_return;
      push_ff <= irq_take;
      irq_ack_ff <= irq_take;
      if (irq_take)
        push_data_ff <= stack_top_i;
    end
  end

  assign mem_we_o = mem_we_ff;
  assign mem_waddr_o = mem_waddr_ff;
  assign mem_wdata_o = mem_wdata_ff;
  assign stack_pop_o = pop_ff;
  assign stack_push_o = push_ff;
  assign stack_push_data_o = push_data_ff;
  assign global_interrupt_enable_o = gie_ff;
  assign irq_ack_o = irq_ack_ff;
  assign pc_o = pc_ff;
  assign acc_o = acc_ff;
  assign zero_o = zero_ff;
  // one-hot: the dummy state bit itself, so the output stays a bare flop
  assign busy_o = state_ff[1];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_idle;
    take && op_i == IDLE_OP |=> pc_ff == $past(pc_ff) + PC_W'(1) && acc_ff == $past(acc_ff)
      && zero_ff == $past(zero_ff) && !mem_we_ff && !pop_ff;
  endproperty
  a_idle: assert property (p_idle) else $error("idle op changed state");

  property p_or_acc;
    take && op_i == OR_MEM_TO_ACC_OP |=> acc_ff == ($past(acc_ff) | $past(mem_rdata_i))
      && zero_ff == (($past(acc_ff) | $past(mem_rdata_i)) == '0);
  endproperty
  a_or_acc: assert property (p_or_acc) else $error("memory OR into acc wrong");

  property p_or_imm;
    take && op_i == OR_IMM_TO_ACC_OP |=> acc_ff == ($past(acc_ff) | $past(imm_i))
      && !mem_we_ff;
  endproperty
  a_or_imm: assert property (p_or_imm) else $error("immediate OR wrong");

  property p_or_mem;
    take && op_i == OR_INTO_MEMORY_OP |=> mem_we_ff && acc_ff == $past(acc_ff)
      && mem_wdata_ff == ($past(acc_ff) | $past(mem_rdata_i)) && mem_waddr_ff == $past(mem_addr_i);
  endproperty
  a_or_mem: assert property (p_or_mem) else $error("OR into memory wrong");

  property p_sub_exit;
    take && (op_i == SUBROUTINE_EXIT_OP || op_i == SUBROUTINE_EXIT_LOAD_OP)
      |=> pc_ff == $past(stack_top_i) && zero_ff == $past(zero_ff) && pop_ff && busy_o;
  endproperty
  a_sub_exit: assert property (p_sub_exit) else $error("subroutine exit wrong");

  property p_exit_load;
    take && op_i == SUBROUTINE_EXIT_LOAD_OP |=> acc_ff == $past(imm_i);
  endproperty
  a_exit_load: assert property (p_exit_load) else $error("exit load of acc wrong");

  property p_int_exit;
    take && op_i == INTERRUPT_EXIT_OP |=> gie_ff && pop_ff && zero_ff == $past(zero_ff);
  endproperty
  a_int_exit: assert property (p_int_exit) else $error("interrupt exit wrong");

  property p_pending;
    irq_take |=> pc_ff == IRQ_VECTOR && push_ff && irq_ack_ff
      && push_data_ff == $past(stack_top_i);
  endproperty
  a_pending: assert property (p_pending) else $error("pending irq not served");

  property p_rot;
    take && op_i == ROTATE_LEFT_OP |=> mem_we_ff && zero_ff == $past(zero_ff)
      && mem_wdata_ff == {$past(mem_rdata_i[ROT_MSB-1:0]), $past(mem_rdata_i[ROT_MSB])};
  endproperty
  a_rot: assert property (p_rot) else $error("rotate left wrong");

  property p_dummy;
    take && op_i == UNCONDITIONAL_JUMP_OP && ce_i |=> busy_o && pc_ff == $past(jump_addr_i)
      ##1 (!ce_i || !busy_o);
  endproperty
  a_dummy: assert property (p_dummy) else $error("jump dummy cycle wrong");

  property p_pop_once;
    pop_ff |-> !$past(pop_ff) || !$past(ce_i);
  endproperty
  a_pop_once: assert property (p_pop_once) else $error("stack popped twice");
endmodule

// ===== rtl/exec_pkg.sv
package exec_pkg;
  // widths
  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  // reset values
  localparam logic [PC_W-1:0] PC_RST = 12'h000;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic ZERO_RST = 1'b0;
  localparam logic GIE_RST = 1'b0;
  // interrupt entry address, arbitrary value
  localparam logic [PC_W-1:0] IRQ_VECTOR = 12'h004;
  // the bit that wraps and the bit it wraps into
  localparam int ROT_MSB = 7;
  localparam int ROT_LSB = 0;
  // instruction codes presented by the decoder
  typedef enum logic [3:0] {
    IDLE_OP = 4'h0,
    OR_MEM_TO_ACC_OP = 4'h1,
    OR_IMM_TO_ACC_OP = 4'h2,
    OR_INTO_MEMORY_OP = 4'h3,
    SUBROUTINE_EXIT_OP = 4'h4,
    SUBROUTINE_EXIT_LOAD_OP = 4'h5,
    INTERRUPT_EXIT_OP = 4'h6,
    ROTATE_LEFT_OP = 4'h7,
    UNCONDITIONAL_JUMP_OP = 4'h8
  } op_e;
  typedef enum logic [1:0] {
    ST_EXEC = 2'h1,
    ST_DUMMY = 2'h2
  } state_e;
endpackage

// ===== rtl/alu_if.sv
`timescale 1ns/1ps
interface alu_if;
  import exec_pkg::*;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] or_res;
  logic [DATA_W-1:0] rot_res;
  logic or_zero;
  modport core (output acc, output operand, input or_res, input rot_res, input or_zero);
  modport alu (input acc, input operand, output or_res, output rot_res, output or_zero);
endinterface

// ===== rtl/bit_alu.sv
`timescale 1ns/1ps
module bit_alu
  import exec_pkg::*;
(
  alu_if.alu a
);
  genvar i;
  generate
    for (i = 0; i < DATA_W; i++)
    begin : g_bit
      assign a.or_res[i] = a.acc[i] | a.operand[i];
      if (i == ROT_LSB)
      begin : g_wrap
        assign a.rot_res[i] = a.operand[ROT_MSB];
      end
      else
      begin : g_shift
        assign a.rot_res[i] = a.operand[i-1];
      end
    end
  endgenerate
  assign a.or_zero = ~|a.or_res;
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import exec_pkg::*;
  typedef struct {op_e op; logic [7:0] imm; logic [7:0] rd; logic [7:0] acc; logic z;
    logic we; logic [7:0] wd;} row_s;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic instr_valid_i = 1'b0;
  op_e op_i = IDLE_OP;
  logic [DATA_W-1:0] imm_i = 8'h00;
  logic [DATA_W-1:0] mem_addr_i = 8'h00;
  logic [DATA_W-1:0] mem_rdata_i = 8'h00;
  logic [PC_W-1:0] jump_addr_i = 12'h000;
  logic [PC_W-1:0] stack_top_i = 12'h000;
  logic irq_pending_i = 1'b0;
  logic gie_clear_i = 1'b0;
  logic mem_we_o, stack_pop_o, stack_push_o, global_interrupt_enable_o, irq_ack_o;
  logic zero_o, busy_o;
  logic [DATA_W-1:0] mem_waddr_o, mem_wdata_o, acc_o;
  logic [PC_W-1:0] stack_push_data_o, pc_o;
  int n_errors = 0;
  int n_tests = 0;
  logic [PC_W-1:0] exp_pc;
  logic ret;
  // one row per instruction, state carries over from row to row
  row_s rows [12] = '{
    '{OR_IMM_TO_ACC_OP, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
    '{OR_IMM_TO_ACC_OP, 8'h05, 8'h00, 8'h05, 1'b0, 1'b0, 8'h00},
    '{OR_MEM_TO_ACC_OP, 8'h00, 8'hA0, 8'hA5, 1'b0, 1'b0, 8'h00},
    '{OR_INTO_MEMORY_OP, 8'h00, 8'h18, 8'hA5, 1'b0, 1'b1, 8'hBD},
    '{IDLE_OP, 8'hFF, 8'hFF, 8'hA5, 1'b0, 1'b0, 8'h00},
    '{ROTATE_LEFT_OP, 8'h00, 8'h81, 8'hA5, 1'b0, 1'b1, 8'h03},
    '{SUBROUTINE_EXIT_LOAD_OP, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00},
    '{OR_INTO_MEMORY_OP, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00},
    '{ROTATE_LEFT_OP, 8'h00, 8'h40, 8'h00, 1'b1, 1'b1, 8'h80},
    '{SUBROUTINE_EXIT_OP, 8'h77, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
    '{OR_MEM_TO_ACC_OP, 8'h00, 8'h3C, 8'h3C, 1'b0, 1'b0, 8'h00},
    '{IDLE_OP, 8'h00, 8'h00, 8'h3C, 1'b0, 1'b0, 8'h00}};

  always #4 clk_i = ~clk_i;

  or_return_rotate_exec or_return_rotate_exec_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .ce_i(ce_i), .instr_valid_i(instr_valid_i), .op_i(op_i), .imm_i(imm_i),
    .mem_addr_i(mem_addr_i), .jump_addr_i(jump_addr_i), .mem_rdata_i(mem_rdata_i),
    .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o),
    .stack_top_i(stack_top_i), .stack_pop_o(stack_pop_o), .stack_push_o(stack_push_o),
    .stack_push_data_o(stack_push_data_o), .irq_pending_i(irq_pending_i),
    .gie_clear_i(gie_clear_i), .global_interrupt_enable_o(global_interrupt_enable_o),
    .irq_ack_o(irq_ack_o), .pc_o(pc_o), .acc_o(acc_o), .zero_o(zero_o), .busy_o(busy_o));

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // called at a falling edge; returns at the falling edge after the taking edge
  task automatic issue(input op_e op, input logic [7:0] imm, input logic [7:0] rd);
    op_i = op;
    imm_i = imm;
    mem_rdata_i = rd;
    instr_valid_i = 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    instr_valid_i = 1'b0;
  endtask

  // bounded wait for the dummy cycle to end
  task automatic wait_idle;
    int k;
    k = 0;
    while (busy_o !== 1'b0 && k < 4)
    begin
      @(negedge clk_i);
      k++;
    end
    if (busy_o !== 1'b0)
    begin
      n_errors++;
      $display("FAIL %0t busy stuck", $time);
      complete_run();
    end
  endtask

  initial
  begin
    repeat (5) @(negedge clk_i);
    chk(pc_o, PC_RST, "reset pc");
    chk(12'(acc_o), 12'(ACC_RST), "reset acc");
    chk(12'({zero_o, global_interrupt_enable_o, busy_o, mem_we_o}), 12'h000, "reset flags");
    reset_n_i = 1'b1;
    @(negedge clk_i);
    exp_pc = pc_o;
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      mem_addr_i = 8'h20 + 8'(i);
      stack_top_i = 12'h300 + 12'(i);
      ret = rows[i].op inside {SUBROUTINE_EXIT_OP, SUBROUTINE_EXIT_LOAD_OP};
      issue(rows[i].op, rows[i].imm, rows[i].rd);
      exp_pc = ret ? stack_top_i : exp_pc + 12'h001;
      chk(12'(acc_o), 12'(rows[i].acc), "acc");
      chk(12'(zero_o), 12'(rows[i].z), "zero");
      chk(12'(mem_we_o), 12'(rows[i].we), "we");
      if (rows[i].we === 1'b1)
      begin
        chk(12'(mem_waddr_o), 12'(mem_addr_i), "waddr");
        chk(12'(mem_wdata_o), 12'(rows[i].wd), "wdata");
      end
      chk(pc_o, exp_pc, "pc");
      chk(12'({stack_pop_o, busy_o}), 12'({ret, ret}), "pop");
      if (ret === 1'b1)
      begin
        wait_idle();
        chk(12'(stack_pop_o), 12'h000, "pop pulse");
        exp_pc = pc_o;
      end
    end
    $display("test rows done");
    ce_i = 1'b0;
    issue(OR_IMM_TO_ACC_OP, 8'hFF, 8'h00);
    chk(12'(acc_o), 12'h03C, "ce hold acc");
    chk(pc_o, exp_pc, "ce hold pc");
    ce_i = 1'b1;
    $display("test enable done");
    stack_top_i = 12'h155;
    issue(INTERRUPT_EXIT_OP, 8'h00, 8'h00);
    chk(pc_o, 12'h155, "interrupt_exit_op pc");
    chk(12'({global_interrupt_enable_o, stack_pop_o, irq_ack_o}), 12'h006, "interrupt_exit_op");
    chk(12'({acc_o, zero_o}), 12'h078, "interrupt_exit_op keep");
    wait_idle();
    gie_clear_i = 1'b1;
    @(negedge clk_i);
    gie_clear_i = 1'b0;
    chk(12'(global_interrupt_enable_o), 12'h000, "gie clr");
    $display("test return from interrupt done");
    // pending request must be taken before the main program resumes
    // a clear in the same cycle must lose to the set
    irq_pending_i = 1'b1;
    gie_clear_i = 1'b1;
    stack_top_i = 12'h2AA;
    issue(INTERRUPT_EXIT_OP, 8'h00, 8'h00);
    irq_pending_i = 1'b0;
    gie_clear_i = 1'b0;
    chk(pc_o, IRQ_VECTOR, "pend pc");
    chk(stack_push_data_o, 12'h2AA, "pend push");
    chk(12'({stack_push_o, irq_ack_o, global_interrupt_enable_o}), 12'h007, "pend");
    wait_idle();
    chk(12'({stack_push_o, irq_ack_o}), 12'h000, "pend pulse");
    $display("test pending interrupt done");
    jump_addr_i = 12'h7E1;
    issue(UNCONDITIONAL_JUMP_OP, 8'h00, 8'h00);
    chk(pc_o, 12'h7E1, "jump pc");
    chk(12'(busy_o), 12'h001, "jump busy");
    issue(OR_IMM_TO_ACC_OP, 8'hFF, 8'h00);
    chk(12'(acc_o), 12'h03C, "dummy ignored");
    chk(12'(busy_o), 12'h000, "jump done");
    chk(pc_o, 12'h7E1, "dummy pc");
    $display("test jump done");
    // asynchronous: outputs must clear without a clock edge
    reset_n_i = 1'b0;
    #1;
    chk(pc_o, PC_RST, "async reset pc");
    chk(12'(acc_o), 12'(ACC_RST), "async reset acc");
    chk(12'({zero_o, global_interrupt_enable_o, busy_o}), 12'h000, "async reset flags");
    @(negedge clk_i);
    reset_n_i = 1'b1;
    @(negedge clk_i);
    chk(pc_o, PC_RST, "after reset pc");
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
